// File: hw/iam_consts.vh
// Constants of the index address modifier: register offsets, fields, timing.
// Assumes inclusion by bare name from the hw/ folder.
`ifndef IAM_CONSTS_VH
`define IAM_CONSTS_VH

// Register byte offsets
`define IAM_OFF_OPADDR   8'h00
`define IAM_OFF_OPP      8'h04
`define IAM_OFF_OPQ      8'h08
`define IAM_OFF_BANK     8'h0c
`define IAM_OFF_IXCMD    8'h10
`define IAM_OFF_IXRES    8'h14
`define IAM_OFF_STATUS   8'h18
`define IAM_OFF_IXLOC    8'h1c

// Operand address write fields
`define IAM_ADDR_LSB     0
`define IAM_ADDR_MSB     19
`define IAM_FLAG_LSB     20
`define IAM_FLAG_MSB     22
`define IAM_BIT_INDIR    23
`define IAM_BIT_CORE     24
`define IAM_BIT_QSEL     25

// Index command fields
`define IAM_MOD_LSB      0
`define IAM_MOD_MSB      19
`define IAM_BIT_MODNEG   20
`define IAM_SEL_LSB      21
`define IAM_SEL_MSB      23
`define IAM_OP_LSB       24
`define IAM_OP_MSB       27

// Index operation digits (second digit of codes 61..67)
`define IAM_OP_BX        4'h1
`define IAM_OP_BXM       4'h2
`define IAM_OP_BCX       4'h3
`define IAM_OP_BCXM      4'h4
`define IAM_OP_BLX       4'h5
`define IAM_OP_BLXM      4'h6
`define IAM_OP_BSX       4'h7

// Status bits
`define IAM_ST_BUSY      0
`define IAM_ST_ADDRCHK   1
`define IAM_ST_INVALID   2
`define IAM_ST_INDIR     3
`define IAM_ST_BRANCH    4

// Bank codes and reset value
`define IAM_BANK_NONE    2'h0
`define IAM_BANK_ONE     2'h1
`define IAM_BANK_TWO     2'h2
`define IAM_BANK_RESET   2'h0

// Core locations of register storage
`define IAM_LOC_BANK1    9'h131
`define IAM_LOC_BANK2    9'h159
`define IAM_LOC_PSEUDO1  9'h12c
`define IAM_LOC_PSEUDO2  9'h154
`define IAM_LOC_STEP     9'h005

// Timing
`define IAM_CLK_NS       50
`define IAM_IDX_EXTRA_NS 50000

`endif

// File: hw/iam_ix_mem.v
// Storage of both index register bands plus their pseudo register zero.
// Assumes one clock; read data registered, valid one edge after address.
`timescale 1ns/10ps
module iam_ix_mem #(
    parameter AW = 4,
    parameter DW = 21
) (
    // Clock
    input  wire          ref_clk,
    // Write port
    input  wire          wrEn,
    input  wire [AW-1:0] wrAddr,
    input  wire [DW-1:0] wrData,
    // Read port
    input  wire [AW-1:0] rdAddr,
    output reg  [DW-1:0] rdData
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule // iam_ix_mem

// File: hw/iam_dec_serial.v
// Digit-serial five digit decimal adder; subtract adds the ten's complement.
// Assumes start is a one-cycle pulse and is not repeated before done.
`timescale 1ns/10ps
module iam_dec_serial #(
    parameter DIGITS = 5
) (
    // Clock and reset
    input  wire                ref_clk,
    input  wire                rst_n,
    // Request
    input  wire                start,
    input  wire [4*DIGITS-1:0] aIn,
    input  wire [4*DIGITS-1:0] bIn,
    input  wire                sub,
    // Answer
    output reg  [4*DIGITS-1:0] sumOut,
    output reg                 carryOut,
    output reg                 done
);
    reg [4*DIGITS-1:0] aSh_q;
    reg [4*DIGITS-1:0] bSh_q;
    reg                sub_q;
    reg                carry_q;
    reg                busy_q;
    reg [3:0]          cnt_q;
    wire [4:0]         digSum;

    function [4:0] digAdd;
        input [3:0] a;
        input [3:0] b;
        input       s;
        input       c;
        reg   [4:0] t;
        begin
            t = {1'b0, a} + {1'b0, (s ? (4'h9 - b) : b)} + {4'h0, c};
            digAdd = (t > 5'h09) ? {1'b1, t[3:0] - 4'ha} : t;
        end
    endfunction

    assign digSum = digAdd(aSh_q[3:0], bSh_q[3:0], sub_q, carry_q);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            aSh_q    <= {4*DIGITS{1'b0}};
            bSh_q    <= {4*DIGITS{1'b0}};
            sub_q    <= 1'b0;
            carry_q  <= 1'b0;
            busy_q   <= 1'b0;
            cnt_q    <= 4'h0;
            sumOut   <= {4*DIGITS{1'b0}};
            carryOut <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                aSh_q   <= aIn;
                bSh_q   <= bIn;
                sub_q   <= sub;
                carry_q <= sub;
                cnt_q   <= 4'h0;
                busy_q  <= 1'b1;
            end else if (busy_q) begin
                // Units digit first, one digit per edge
                aSh_q   <= aSh_q >> 4;
                bSh_q   <= bSh_q >> 4;
                sumOut  <= {digSum[3:0], sumOut[4*DIGITS-1:4]};
                carry_q <= digSum[4];
                cnt_q   <= cnt_q + 4'h1;
                if (cnt_q == DIGITS - 1) begin
                    busy_q   <= 1'b0;
                    carryOut <= digSum[4];
                    done     <= 1'b1;
                end
            end
        end
    end
endmodule // iam_dec_serial

// File: hw/iam_index_modifier.v
// Index address modifier: two bands of index registers, address indexing,
// register modification and bank selection behind a plain register port.
// Assumes one 20 MHz clock; software fetches indirect words itself.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "iam_consts.vh"
module iam_index_modifier #(
    parameter DIGITS    = 5,
    parameter FETCH_CYC = (`IAM_IDX_EXTRA_NS + `IAM_CLK_NS - 1) / `IAM_CLK_NS
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        consoleReset,
    // Register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdData,
    // Status outputs
    output reg         fetchBusy,
    output reg         haltReq,
    output reg         memAddrCheck
);
    localparam AW = 4 * DIGITS;
    localparam S_IDLE = 4'h0, S_A_RD = 4'h1, S_A_GO = 4'h2, S_A_ADD = 4'h3, S_STALL = 4'h4;
    localparam S_M_RD = 4'h5, S_M_GO = 4'h6, S_M_ADD = 4'h7, S_M_FIX = 4'h8, S_M_WR = 4'h9;

    reg  [3:0]    state_q;
    reg  [1:0]    bank_q;
    reg  [25:0]   opAddr_q;
    reg  [AW-1:0] opP_q;
    reg  [AW-1:0] opQ_q;
    reg  [27:0]   ixCmd_q;
    reg  [AW:0]   ixRes_q;
    reg  [8:0]    ixLoc_q;
    reg  [9:0]    stall_q;
    reg  [AW-1:0] effAddr_q;
    reg           addrChk_q;
    reg           invalid_q;
    reg           indir_q;
    reg           branch_q;
    reg           xSign_q;
    reg           subMode_q;
    reg  [3:0]    memAddr_q;
    reg           memWr_q;
    reg  [AW:0]   memWrData_q;
    reg           addStart_q;
    reg  [AW-1:0] addA_q;
    reg  [AW-1:0] addB_q;
    reg           addSub_q;
    wire [AW:0]   memRd;
    wire [AW-1:0] addSum;
    wire          addCarry;
    wire          addDone;
    wire          busy;
    wire          wrAddr;
    wire          wrCmd;
    wire          setChk;
    wire          setInv;
    wire          setIndir;
    wire [2:0]    addrSel;
    wire [2:0]    cmdSel;
    wire [3:0]    cmdOp;
    reg  [31:0]   rdMux;

    // Binary location of a register in core storage
    function [8:0] ixLoc;
        input [1:0] bank;
        input [2:0] sel;
        begin
            if (sel == 3'h0) begin
                ixLoc = (bank == `IAM_BANK_TWO) ? `IAM_LOC_PSEUDO2 : `IAM_LOC_PSEUDO1;
            end else begin
                ixLoc = ((bank == `IAM_BANK_TWO) ? `IAM_LOC_BANK2 : `IAM_LOC_BANK1)
                        + `IAM_LOC_STEP * {6'h0, sel - 3'h1};
            end
        end
    endfunction

    assign busy     = (state_q != S_IDLE);
    assign wrAddr   = regWr && (regAddr == `IAM_OFF_OPADDR) && !busy;
    assign wrCmd    = regWr && (regAddr == `IAM_OFF_IXCMD) && !busy;
    assign addrSel  = regWrData[`IAM_FLAG_MSB:`IAM_FLAG_LSB];
    assign cmdSel   = regWrData[`IAM_SEL_MSB:`IAM_SEL_LSB];
    assign cmdOp    = regWrData[`IAM_OP_MSB:`IAM_OP_LSB];
    assign setChk   = (state_q == S_A_ADD) && addDone && addSub_q && !addCarry;
    assign setInv   = wrCmd && (bank_q == `IAM_BANK_NONE)
                      && (cmdOp >= `IAM_OP_BX) && (cmdOp <= `IAM_OP_BSX);
    assign setIndir = wrAddr && regWrData[`IAM_BIT_INDIR];

    iam_ix_mem #(.AW(4), .DW(AW + 1)) u_mem (
        .ref_clk (ref_clk),
        .wrEn    (memWr_q),
        .wrAddr  (memAddr_q),
        .wrData  (memWrData_q),
        .rdAddr  (memAddr_q),
        .rdData  (memRd)
    );

    iam_dec_serial #(.DIGITS(DIGITS)) u_add (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .start    (addStart_q),
        .aIn      (addA_q),
        .bIn      (addB_q),
        .sub      (addSub_q),
        .sumOut   (addSum),
        .carryOut (addCarry),
        .done     (addDone)
    );

    // Bank selection survives console reset, only power-up or a bank write of 0 clears it
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            bank_q <= `IAM_BANK_RESET;
        end else if (regWr && (regAddr == `IAM_OFF_BANK) && (regWrData[1:0] != 2'h3)) begin
            bank_q <= regWrData[1:0];
        end
    end

    // Sticky flags: a set in the same cycle as a clear wins
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            addrChk_q <= 1'b0;
            invalid_q <= 1'b0;
            indir_q   <= 1'b0;
        end else begin
            if (consoleReset || (regWr && (regAddr == `IAM_OFF_STATUS))) begin
                addrChk_q <= consoleReset ? 1'b0 : addrChk_q & ~regWrData[`IAM_ST_ADDRCHK];
                invalid_q <= consoleReset ? 1'b0 : invalid_q & ~regWrData[`IAM_ST_INVALID];
                indir_q   <= consoleReset ? 1'b0 : indir_q & ~regWrData[`IAM_ST_INDIR];
            end
            if (setChk) addrChk_q <= 1'b1;
            if (setInv) invalid_q <= 1'b1;
            if (setIndir) indir_q <= 1'b1;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q     <= S_IDLE;
            opAddr_q    <= 26'h0;
            opP_q       <= {AW{1'b0}};
            opQ_q       <= {AW{1'b0}};
            ixCmd_q     <= 28'h0;
            ixRes_q     <= {(AW+1){1'b0}};
            ixLoc_q     <= 9'h0;
            stall_q     <= 10'h0;
            effAddr_q   <= {AW{1'b0}};
            branch_q    <= 1'b0;
            xSign_q     <= 1'b0;
            subMode_q   <= 1'b0;
            memAddr_q   <= 4'h0;
            memWr_q     <= 1'b0;
            memWrData_q <= {(AW+1){1'b0}};
            addStart_q  <= 1'b0;
            addA_q      <= {AW{1'b0}};
            addB_q      <= {AW{1'b0}};
            addSub_q    <= 1'b0;
        end else begin
            addStart_q <= 1'b0;
            memWr_q    <= 1'b0;
            case (state_q)
            S_IDLE: begin
                if (wrAddr) begin
                    opAddr_q  <= regWrData[25:0];
                    effAddr_q <= regWrData[`IAM_ADDR_MSB:`IAM_ADDR_LSB];
                    memAddr_q <= {bank_q == `IAM_BANK_TWO, addrSel};
                    // Flags stripped; register zero never used for addresses
                    if (addrSel != 3'h0 && regWrData[`IAM_BIT_CORE]
                        && bank_q != `IAM_BANK_NONE) begin
                        state_q <= S_A_RD;
                    end else if (regWrData[`IAM_BIT_QSEL]) begin
                        opQ_q <= regWrData[`IAM_ADDR_MSB:`IAM_ADDR_LSB];
                    end else begin
                        opP_q <= regWrData[`IAM_ADDR_MSB:`IAM_ADDR_LSB];
                    end
                end else if (wrCmd && !setInv && cmdOp >= `IAM_OP_BX && cmdOp <= `IAM_OP_BSX) begin
                    ixCmd_q   <= regWrData[27:0];
                    memAddr_q <= {bank_q == `IAM_BANK_TWO, cmdSel};
                    ixLoc_q   <= ixLoc(bank_q, cmdSel);
                    state_q   <= S_M_RD;
                end
            end
            S_A_RD: state_q <= S_A_GO;
            S_A_GO: begin
                // Magnitude only, sign bit decides add or complement add
                addA_q     <= effAddr_q;
                addB_q     <= memRd[AW-1:0];
                addSub_q   <= memRd[AW];
                addStart_q <= 1'b1;
                state_q    <= S_A_ADD;
            end
            S_A_ADD: begin
                if (addDone) begin
                    // Top carry dropped; a borrow leaves the ten's complement
                    effAddr_q <= addSum;
                    stall_q   <= 10'h0;
                    state_q   <= S_STALL;
                end
            end
            S_STALL: begin
                stall_q <= stall_q + 10'h1;
                if (stall_q == FETCH_CYC - 1) begin
                    // Sum lands in the operand register only; a borrow in the add has already set the address check
                    if (opAddr_q[`IAM_BIT_QSEL]) begin
                        opQ_q <= effAddr_q;
                    end else begin
                        opP_q <= effAddr_q;
                    end
                    state_q <= S_IDLE;
                end
            end
            S_M_RD: state_q <= S_M_GO;
            S_M_GO: begin
                xSign_q <= memRd[AW];
                if (ixCmd_q[`IAM_OP_MSB:`IAM_OP_LSB] == `IAM_OP_BSX) begin
                    ixRes_q <= memRd;
                    state_q <= S_IDLE;
                end else if (ixCmd_q[`IAM_OP_MSB:`IAM_OP_LSB] >= `IAM_OP_BLX) begin
                    ixRes_q <= ixCmd_q[AW:0];
                    state_q <= S_M_WR;
                end else begin
                    addA_q     <= memRd[AW-1:0];
                    addB_q     <= ixCmd_q[AW-1:0];
                    addSub_q   <= memRd[AW] ^ ixCmd_q[`IAM_BIT_MODNEG];
                    subMode_q  <= memRd[AW] ^ ixCmd_q[`IAM_BIT_MODNEG];
                    addStart_q <= 1'b1;
                    state_q    <= S_M_ADD;
                end
            end
            S_M_ADD: begin
                if (addDone) begin
                    if (!subMode_q || addCarry) begin
                        // No sign change: an add's overflow digit is lost and refuses the branch
                        ixRes_q  <= {xSign_q, addSum};
                        branch_q <= (addSum != {AW{1'b0}}) && !(!subMode_q && addCarry);
                        state_q  <= S_M_WR;
                    end else begin
                        // Sign change: recomplement to true magnitude
                        addA_q     <= {AW{1'b0}};
                        addB_q     <= addSum;
                        addSub_q   <= 1'b1;
                        addStart_q <= 1'b1;
                        state_q    <= S_M_FIX;
                    end
                end
            end
            S_M_FIX: begin
                if (addDone) begin
                    ixRes_q  <= {~xSign_q, addSum};
                    branch_q <= 1'b0;
                    state_q  <= S_M_WR;
                end
            end
            S_M_WR: begin
                memWr_q     <= 1'b1;
                memWrData_q <= ixRes_q;
                state_q     <= S_IDLE;
            end
            default: state_q <= S_IDLE;
            endcase
        end
    end

    // Read decode; indicator reads have no side effect
    always @* begin
        rdMux = 32'h0;
        if (regAddr == `IAM_OFF_OPADDR) begin
            rdMux = {6'h0, opAddr_q};
        end else if (regAddr == `IAM_OFF_OPP) begin
            rdMux = {{(32-AW){1'b0}}, opP_q};
        end else if (regAddr == `IAM_OFF_OPQ) begin
            rdMux = {{(32-AW){1'b0}}, opQ_q};
        end else if (regAddr == `IAM_OFF_BANK) begin
            rdMux = {29'h0, bank_q == `IAM_BANK_TWO, bank_q == `IAM_BANK_ONE,
                     bank_q == `IAM_BANK_NONE};
        end else if (regAddr == `IAM_OFF_IXCMD) begin
            rdMux = {4'h0, ixCmd_q};
        end else if (regAddr == `IAM_OFF_IXRES) begin
            rdMux = {{(31-AW){1'b0}}, ixRes_q};
        end else if (regAddr == `IAM_OFF_STATUS) begin
            rdMux = {27'h0, branch_q, indir_q, invalid_q, addrChk_q, busy};
        end else if (regAddr == `IAM_OFF_IXLOC) begin
            rdMux = {23'h0, ixLoc_q};
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            regRdData    <= 32'h0;
            fetchBusy    <= 1'b0;
            haltReq      <= 1'b0;
            memAddrCheck <= 1'b0;
        end else begin
            regRdData    <= regRd ? rdMux : 32'h0;
            fetchBusy    <= busy;
            haltReq      <= invalid_q;
            memAddrCheck <= addrChk_q;
        end
    end
endmodule // iam_index_modifier

// File: testbench/iam_chk.sv
// Port checker for the index address modifier.
// Assumes it is bound to iam_index_modifier and sees only its ports.
`timescale 1ns/10ps
module iam_chk #(
    parameter FETCH_CYC = 10
) (
    // Clock and reset
    input wire        ref_clk,
    input wire        rst_n,
    input wire        consoleReset,
    // Register port
    input wire [7:0]  regAddr,
    input wire [31:0] regWrData,
    input wire        regWr,
    input wire        regRd,
    input wire [31:0] regRdData,
    // Status
    input wire        fetchBusy,
    input wire        haltReq,
    input wire        memAddrCheck
);
    logic [15:0] busyCnt_q;
    logic [15:0] busyCnt_d;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    assign busyCnt_d = fetchBusy ? busyCnt_q + 16'h1 : 16'h0;
    always @(posedge ref_clk) begin
        busyCnt_q <= rst_n ? busyCnt_d : 16'h0;
    end

    bank_onehot_a: assert property (regRd && regAddr == 8'h0c |=>
        $onehot(regRdData[2:0]) && regRdData[31:3] == 29'h0) else $error("bank indicators not one-hot");
    bank_write_a: assert property (regWr && regAddr == 8'h0c && regWrData[1:0] != 2'h3 ##2
        regRd && regAddr == 8'h0c |=> regRdData[2:0] == (3'h1 << $past(regWrData[1:0], 3)))
        else $error("bank indicator does not follow selection");
    halt_cause_a: assert property ($rose(haltReq) |->
        $past(regWr, 2) && $past(regAddr, 2) == 8'h10) else $error("halt without index command");
    halt_hold_a: assert property (haltReq && !consoleReset && !$past(consoleReset) && !regWr
        && !$past(regWr) |=> haltReq) else $error("halt dropped by itself");
    addr_check_cause_a: assert property ($rose(memAddrCheck) |->
        $past(fetchBusy) || $past(fetchBusy, 2) || $past(fetchBusy, 3)) else $error("check without indexing");
    fetch_bound_a: assert property (fetchBusy |-> busyCnt_q <= FETCH_CYC + 20)
        else $error("fetch stall too long");
    console_clear_a: assert property (consoleReset && !regWr && !fetchBusy |-> ##2
        !haltReq && !memAddrCheck) else $error("console reset left flags set");
    power_idle_a: assert property (disable iff (1'b0) !rst_n |=>
        !fetchBusy && !haltReq && !memAddrCheck && regRdData == 32'h0) else $error("outputs not idle in reset");
    status_mirror_a: assert property (regRd && regAddr == 8'h18 |=>
        regRdData[2] == haltReq && regRdData[1] == memAddrCheck) else $error("status and pins disagree");

    cover property (regWr && regAddr == 8'h10);
    cover property ($rose(memAddrCheck));
    cover property ($fell(fetchBusy));
endmodule // iam_chk

// File: testbench/iam_fetch_model.sv
// Model of the fetch sequencer that drives the modifier's register port.
// Assumes one clock; read data arrive in the cycle after the strobe.
`timescale 1ns/10ps
module iam_fetch_model (
    // Clock
    input  wire         ref_clk,
    // Register port
    output logic [7:0]  regAddr,
    output logic [31:0] regWrData,
    output logic        regWr,
    output logic        regRd,
    input  wire  [31:0] regRdData
);
    initial begin
        regAddr = 8'h0;
        regWrData = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    // Released lines show the inverse so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        #1 d = regRdData;
    endtask

    // Command word has no indirect mark on its data operand
    task automatic ixcmd(input logic [3:0] op, input logic [2:0] sel, input logic neg, input logic [19:0] m);
        wr(8'h10, {4'h0, op, sel, neg, m});
    endtask

    task automatic opaddr(input logic q, input logic ind, input logic core, input logic [2:0] f,
                          input logic [19:0] a);
        wr(8'h00, {6'h0, q, core, ind, f, a});
    endtask
endmodule // iam_fetch_model

// File: testbench/tb.sv
// Self-checking bench for the index address modifier.
// Assumes the fetch model drives the register port; checker bound below.
`timescale 1ns/10ps
module tb;
    localparam FC = 10;
    logic        ref_clk;
    logic        rst_n;
    logic        consoleReset;
    wire  [7:0]  regAddr;
    wire  [31:0] regWrData;
    wire  [31:0] regRdData;
    wire         regWr;
    wire         regRd;
    wire         fetchBusy;
    wire         haltReq;
    wire         memAddrCheck;
    int          n_errors;
    int          cmp_count;
    int          busyN;
    logic [31:0] d;

    iam_index_modifier #(.FETCH_CYC(FC)) iam_index_modifier_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .consoleReset(consoleReset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .fetchBusy(fetchBusy), .haltReq(haltReq),
        .memAddrCheck(memAddrCheck));
    iam_fetch_model iam_fetch_model_inst (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] v;
        iam_fetch_model_inst.rd(a, v);
        check(nm, v, exp);
    endtask

    // Bounded wait; the busy span seen is kept for the stall check
    task automatic wait_idle;
        busyN = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        while (fetchBusy === 1'b1 && busyN < 300) begin
            @(posedge ref_clk);
            #1 busyN++;
        end
        if (busyN >= 300) check("idle", 0, 1);
    endtask

    task automatic ix(input logic [3:0] op, input logic [2:0] sel, input logic neg, input logic [19:0] m);
        iam_fetch_model_inst.ixcmd(op, sel, neg, m);
        wait_idle;
    endtask

    task automatic adr(input logic q, input logic ind, input logic core, input logic [2:0] f,
                       input logic [19:0] a);
        iam_fetch_model_inst.opaddr(q, ind, core, f, a);
        wait_idle;
    endtask

    task automatic console_pulse;
        @(posedge ref_clk);
        consoleReset <= 1'b1;
        @(posedge ref_clk);
        consoleReset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic t_load;
        rdc(8'h0c, 32'h1, "bank at power-up");
        iam_fetch_model_inst.wr(8'h0c, 32'h2);
        rdc(8'h0c, 32'h4, "bank two");
        ix(4'h6, 3'h3, 1'b0, 20'h00040);
        rdc(8'h1c, 32'h163, "bank two reg3 loc");
        iam_fetch_model_inst.wr(8'h0c, 32'h1);
        rdc(8'h0c, 32'h2, "bank one");
        ix(4'h5, 3'h3, 1'b0, 20'h00020);
        rdc(8'h1c, 32'h13b, "bank one reg3 loc");
        rdc(8'h14, 32'h00020, "reg3 load");
        ix(4'h6, 3'h7, 1'b0, 20'h00100);
        rdc(8'h1c, 32'h14f, "reg7 loc");
    endtask

    task automatic t_index;
        adr(1'b0, 1'b0, 1'b1, 3'h3, 20'h01000);
        check("stall span", busyN >= FC, 1);
        rdc(8'h04, 32'h01020, "indexed P");
        adr(1'b1, 1'b0, 1'b1, 3'h7, 20'h02000);
        rdc(8'h08, 32'h02100, "indexed Q by reg7");
        adr(1'b1, 1'b0, 1'b0, 3'h3, 20'h00123);
        rdc(8'h08, 32'h00123, "non-core Q");
        ix(4'h6, 3'h0, 1'b0, 20'h00500);
        rdc(8'h1c, 32'h12c, "pseudo one loc");
        adr(1'b0, 1'b0, 1'b1, 3'h0, 20'h00200);
        rdc(8'h04, 32'h00200, "no register used");
        ix(4'h3, 3'h7, 1'b0, 20'h00050);
        rdc(8'h18, 32'h10, "branch on nonzero");
        ix(4'h7, 3'h7, 1'b0, 20'h00000);
        rdc(8'h14, 32'h00150, "reg7 after add");
    endtask

    task automatic t_negative;
        ix(4'h2, 3'h3, 1'b1, 20'h00030);
        rdc(8'h14, 32'h00100010, "reg3 after sign change");
        adr(1'b0, 1'b0, 1'b1, 3'h3, 20'h00005);
        rdc(8'h04, 32'h99995, "complement address");
        check("address check", memAddrCheck, 1);
        rdc(8'h18, 32'h2, "status check bit");
        console_pulse;
        check("check cleared", memAddrCheck, 0);
        rdc(8'h0c, 32'h2, "bank after console");
        adr(1'b0, 1'b1, 1'b1, 3'h3, 20'h01000);
        rdc(8'h04, 32'h00990, "indexed pointer");
        iam_fetch_model_inst.rd(8'h18, d);
        check("indirect pending", d[3], 1);
        console_pulse;
        rdc(8'h18, 32'h0, "flags after console");
    endtask

    task automatic t_nobank;
        logic [3:0] op;
        iam_fetch_model_inst.wr(8'h0c, 32'h0);
        for (op = 4'h1; op <= 4'h7; op++) begin
            iam_fetch_model_inst.ixcmd(op, 3'h1, 1'b0, 20'h00001);
            repeat (3) @(posedge ref_clk);
            #1 check("halt", haltReq, 1);
            console_pulse;
            check("halt cleared", haltReq, 0);
        end
        rdc(8'h0c, 32'h1, "no bank");
        iam_fetch_model_inst.wr(8'h0c, 32'h2);
        ix(4'h6, 3'h0, 1'b0, 20'h00007);
        rdc(8'h1c, 32'h154, "pseudo two loc");
        check("no halt on pseudo", haltReq, 0);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        stop_test;
    end

    initial begin
        n_errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        consoleReset = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_load;
        t_index;
        t_negative;
        t_nobank;
        stop_test;
    end
endmodule // tb

bind iam_index_modifier iam_chk #(.FETCH_CYC(FETCH_CYC)) iam_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .consoleReset(consoleReset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .fetchBusy(fetchBusy), .haltReq(haltReq), .memAddrCheck(memAddrCheck));
